// file: hdl/pcm_pkg.sv
// Constants, field layouts and carrier types for the PCM highway and subscriber timing block.
// Assumes a frame of NUM_SLOTS slots of eight bits each, one highway bit per link clock.
package pcm_pkg;
  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int SLOT_W   = 5;
  localparam int BIT_W    = 3;
  localparam int WORD_W   = 8;
  localparam int NUM_HW   = 2;
  // Link clocks per subscriber word: two per slave clock period
  localparam int SUB_CLKS = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SLOT_W-1:0] RST_SLOT  = 5'h00;
  localparam logic              RST_HW    = 1'b0;
  localparam logic [WORD_W-1:0] RST_WORD  = 8'hff;

  typedef struct packed
  {
    logic [SLOT_W-1:0] rx_slot;
    logic              rx_hw;
    logic [SLOT_W-1:0] tx_slot;
    logic              tx_hw;
    logic [SLOT_W-1:0] strobe_slot;
  } slot_cfg_t;

  localparam slot_cfg_t RST_CFG = '{RST_SLOT, RST_HW, RST_SLOT, RST_HW, RST_SLOT};
endpackage

// file: hdl/pcm_highway_subscriber_timing.sv
// Highway time-slot switch with subscriber serial port, direction, slave clock and strobe.
// Config is written on i_clk; all frame timing runs on the highway link clock.
`timescale 1ns/1ps
module pcm_highway_subscriber_timing
#(
  parameter int NUM_SLOTS = 32
)
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  wire pcm_pkg::slot_cfg_t i_cfg,
  input  wire logic              i_cfg_load,
  input  wire logic              i_link_clk,
  input  wire logic              i_frame_sync_pulse,
  input  wire logic [1:0]        i_rx_highway_data,
  output logic [1:0]             o_tx_highway_data,
  output logic [1:0]             o_tx_highway_oe,
  output logic [1:0]             o_tx_highway_drive_n,
  output logic                   o_slave_clk,
  output logic                   o_dir,
  output logic                   o_programmable_strobe,
  input  wire logic              i_subscriber_serial_port,
  output logic                   o_subscriber_serial_port,
  output logic                   o_subscriber_serial_port_oe
);
  import pcm_pkg::*;

  localparam int P_W = SLOT_W + BIT_W;
  localparam logic [P_W-1:0] HALF       = P_W'(NUM_SLOTS * 4);
  localparam logic [P_W-1:0] FRAME_LAST = P_W'(NUM_SLOTS * 8 - 1);
  localparam logic [P_W-1:0] SUB_LAST   = P_W'(SUB_CLKS);
  // Codec bits launch on the slave clock rise that comes with direction falling and reach sub_s two link clocks later
  localparam logic [P_W-1:0] SMP_FIRST  = HALF + P_W'(3);
  localparam logic [P_W-1:0] SMP_LAST   = HALF + P_W'(SUB_CLKS + 1);

  // ----------------------------------------
  // Config capture on i_clk
  // ----------------------------------------
  slot_cfg_t cfg_hold_ff, nxt_cfg_hold;
  logic      cfg_tog_ff, nxt_cfg_tog;

  always_comb
  begin
    nxt_cfg_hold = cfg_hold_ff;
    nxt_cfg_tog  = cfg_tog_ff;
    if (i_cfg_load)
    begin
      nxt_cfg_hold = i_cfg;
      nxt_cfg_tog  = ~cfg_tog_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_hold_ff <= RST_CFG;
      cfg_tog_ff  <= 1'b0;
    end
    else if (i_ce)
    begin
      cfg_hold_ff <= nxt_cfg_hold;
      cfg_tog_ff  <= nxt_cfg_tog;
    end
  end

  // ----------------------------------------
  // Link domain reset and pin synchronisers
  // ----------------------------------------
  // Hold and toggle stay stable until the toggle is seen, so the word copy is safe
  logic [1:0] lrst_ff;
  logic [5:0] meta_ff, sync_ff;
  logic       lnrst, ce_l, fsp_s, sub_s, tog_s;
  logic [1:0] rxd_s;

  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lrst_ff <= 2'h0;
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
    end
    else
    begin
      lrst_ff <= {lrst_ff[0], 1'b1};
      meta_ff <= {cfg_tog_ff, i_ce, i_subscriber_serial_port, i_frame_sync_pulse, i_rx_highway_data};
      sync_ff <= meta_ff;
    end
  end

  assign lnrst = lrst_ff[1];
  assign {tog_s, ce_l, sub_s, fsp_s, rxd_s} = sync_ff;

  // ----------------------------------------
  // Frame timing and data paths on link clock
  // ----------------------------------------
  slot_cfg_t         cfg_l_ff, nxt_cfg_l;
  logic              tog_d_ff, fsp_d_ff;
  logic [P_W-1:0]    pos_ff, nxt_pos, eff;
  logic [WORD_W-1:0] rx_sr_ff, nxt_rx_sr, rx_word_ff, nxt_rx_word;
  logic [WORD_W-1:0] sub_sr_ff, nxt_sub_sr, tx_word_ff, nxt_tx_word;
  logic [WORD_W-1:0] sub_out_ff, nxt_sub_out;
  logic [1:0]        txd_ff, nxt_txd, txoe_ff, nxt_txoe;
  logic              sclk_ff, nxt_sclk, dir_ff, nxt_dir, stb_ff, nxt_stb;
  logic              sdo_ff, nxt_sdo, sdoe_ff, nxt_sdoe;
  logic              sync_edge, in_rx, in_tx, sub_sample;
  logic [1:0]        aligned_ff, nxt_aligned;
  logic [BIT_W-1:0]  bitn;
  logic              rx_bit;

  always_comb
  begin
    sync_edge = fsp_s & ~fsp_d_ff;
    eff       = sync_edge ? '0 : pos_ff;
    bitn      = eff[BIT_W-1:0];
    in_rx     = eff[P_W-1:BIT_W] == cfg_l_ff.rx_slot;
    in_tx     = eff[P_W-1:BIT_W] == cfg_l_ff.tx_slot;
    rx_bit    = rxd_s[cfg_l_ff.rx_hw];
    nxt_cfg_l = (tog_s ^ tog_d_ff) ? cfg_hold_ff : cfg_l_ff;
    // Slot field steps once every eight bits as the position wraps its low bits
    nxt_pos   = (eff == FRAME_LAST) ? '0 : eff + 1'b1;
    nxt_rx_sr   = in_rx ? {rx_sr_ff[WORD_W-2:0], rx_bit} : rx_sr_ff;
    nxt_rx_word = (in_rx && bitn == 3'h7) ? {rx_sr_ff[WORD_W-2:0], rx_bit} : rx_word_ff;
    nxt_txd  = 2'h0;
    nxt_txoe = 2'h0;
    if (in_tx)
    begin
      nxt_txd[cfg_l_ff.tx_hw]  = tx_word_ff[3'h7 - bitn];
      nxt_txoe[cfg_l_ff.tx_hw] = 1'b1;
    end
    nxt_dir  = eff < HALF;
    // Data and slave clock rise from the same edge so the peripheral sees one launch edge
    nxt_sclk = ~eff[0];
    nxt_sub_out = (eff == '0) ? rx_word_ff : sub_out_ff;
    nxt_sdoe = eff < SUB_LAST;
    // Read the word being loaded so bit 7 of a new frame is not the old word's
    nxt_sdo  = nxt_sdoe ? nxt_sub_out[3'h7 - eff[3:1]] : 1'b0;
    sub_sample  = (eff >= SMP_FIRST) && (eff <= SMP_LAST) && eff[0];
    nxt_sub_sr  = sub_sample ? {sub_sr_ff[WORD_W-2:0], sub_s} : sub_sr_ff;
    // Hand over at frame end so a transmit slot never mixes two codec words
    nxt_tx_word = (eff == FRAME_LAST) ? sub_sr_ff : tx_word_ff;
    nxt_aligned = {aligned_ff[0], aligned_ff[0] | sync_edge};
    nxt_stb  = eff[P_W-1:BIT_W] == cfg_l_ff.strobe_slot;
  end

  always_ff @(posedge i_link_clk or negedge lnrst)
  begin
    if (!lnrst)
    begin
      cfg_l_ff   <= RST_CFG;
      tog_d_ff   <= 1'b0;
      fsp_d_ff   <= 1'b0;
      pos_ff     <= '0;
      rx_sr_ff   <= RST_WORD;
      rx_word_ff <= RST_WORD;
      sub_sr_ff  <= RST_WORD;
      tx_word_ff <= RST_WORD;
      sub_out_ff <= RST_WORD;
      txd_ff     <= 2'h0;
      txoe_ff    <= 2'h0;
      sclk_ff    <= 1'b0;
      dir_ff     <= 1'b0;
      stb_ff     <= 1'b0;
      sdo_ff     <= 1'b0;
      sdoe_ff    <= 1'b0;
      aligned_ff <= 2'h0;
    end
    else if (ce_l)
    begin
      cfg_l_ff   <= nxt_cfg_l;
      tog_d_ff   <= tog_s;
      fsp_d_ff   <= fsp_s;
      pos_ff     <= nxt_pos;
      rx_sr_ff   <= nxt_rx_sr;
      rx_word_ff <= nxt_rx_word;
      sub_sr_ff  <= nxt_sub_sr;
      tx_word_ff <= nxt_tx_word;
      sub_out_ff <= nxt_sub_out;
      txd_ff     <= nxt_txd;
      txoe_ff    <= nxt_txoe;
      sclk_ff    <= nxt_sclk;
      dir_ff     <= nxt_dir;
      stb_ff     <= nxt_stb;
      sdo_ff     <= nxt_sdo;
      sdoe_ff    <= nxt_sdoe;
      aligned_ff <= nxt_aligned;
    end
  end

  assign o_tx_highway_data           = txd_ff;
  assign o_tx_highway_oe             = txoe_ff;
  assign o_tx_highway_drive_n        = ~txoe_ff;
  assign o_slave_clk                 = sclk_ff;
  assign o_dir                       = dir_ff;
  assign o_programmable_strobe       = stb_ff;
  assign o_subscriber_serial_port    = sdo_ff;
  assign o_subscriber_serial_port_oe = sdoe_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_link_clk);
  endclocking
  // Free-running count before the first sync may be cut at any point
  default disable iff (!lnrst || !ce_l || !aligned_ff[1]);

  property p_dir_rise;
    $rose(dir_ff) |-> pos_ff == 8'h01;
  endproperty
  a_dir_rise: assert property (p_dir_rise) else $error("Direction rose off frame start");

  property p_dir_fall;
    $fell(dir_ff) |-> pos_ff == HALF + 1'b1;
  endproperty
  a_dir_fall: assert property (p_dir_fall) else $error("Direction fell off half frame");

  property p_sub_drive;
    sdoe_ff |-> dir_ff;
  endproperty
  a_sub_drive: assert property (p_sub_drive) else $error("Subscriber driven while direction low");

  property p_sub_sample;
    sub_sample |=> !dir_ff;
  endproperty
  a_sub_sample: assert property (p_sub_sample) else $error("Subscriber sampled in wrong half");

  property p_rx_word;
    $changed(rx_word_ff) |-> $past(in_rx) && $past(bitn) == 3'h7;
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("Receive word stored off slot end");

  property p_tx_slot;
    (|txoe_ff) |-> $past(in_tx) && $onehot(txoe_ff);
  endproperty
  a_tx_slot: assert property (p_tx_slot) else $error("Transmit highway driven off slot");

  property p_drive_len;
    $fell(o_tx_highway_drive_n[0]) |-> (!o_tx_highway_drive_n[0])[*8] ##1 o_tx_highway_drive_n[0];
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("Drive flag not low for eight bits");

  property p_sync_reset;
    sync_edge |=> pos_ff == 8'h01;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("Frame sync did not restart counters");

  property p_sclk_launch;
    sdoe_ff && $changed(sdo_ff) |-> $rose(sclk_ff);
  endproperty
  a_sclk_launch: assert property (p_sclk_launch) else $error("Subscriber data off slave clock edge");

  property p_strobe;
    $rose(stb_ff) |-> stb_ff[*8] ##1 !stb_ff;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Strobe not one slot wide");

  property p_slot_step;
    !sync_edge && pos_ff[2:0] == 3'h7 && pos_ff != FRAME_LAST |=>
      pos_ff[P_W-1:BIT_W] == $past(pos_ff[P_W-1:BIT_W]) + 5'h01;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("Slot counter did not step");

  c_sync: cover property (sync_edge);
  c_tx_word: cover property ($fell(o_tx_highway_drive_n[1]));
  c_rx_word: cover property (in_rx && bitn == 3'h7);
  c_sub_word: cover property (sub_sample && eff == SMP_LAST);
endmodule

// file: bench/pcm_peer.sv
// Far side model: highway source with frame sync, plus one subscriber codec.
// Assumes a free-running link clock and that the bench raises i_run once reset is over.
`timescale 1ns/1ps
module pcm_peer
#(
  parameter int NUM_SLOTS = 4
)
(
  input  wire logic       i_link_clk,
  input  wire logic       i_run,
  input  wire logic       i_slave_clk,
  input  wire logic       i_dir,
  output logic            o_frame_sync_pulse,
  output logic [1:0]      o_rx_highway_data,
  output logic            o_codec_data
);
  localparam int BITS = NUM_SLOTS * 8;
  localparam int HALF = BITS / 2;
  int         seed = 82;
  int         pos  = BITS - 1;
  int         frm  = -1;
  int         rxw [0:63][0:NUM_SLOTS-1][0:1];
  int         cdw [0:63];
  logic [1:0] rb;
  logic       sclk_d = 1'b0;
  int         cbit   = 0;
  initial
  begin
    o_frame_sync_pulse = 1'b0;
    o_rx_highway_data  = 2'h0;
    o_codec_data       = 1'b0;
  end
  // -------------------------------
  // Frame, highway and codec timing
  // -------------------------------
  always @(posedge i_link_clk)
  begin
    if (i_run)
    begin
      #1;
      pos = (pos + 1) % BITS;
      if (pos == 0)
        frm++;
      o_frame_sync_pulse = (pos == 0);
      rb = 2'($random(seed));
      o_rx_highway_data = rb;
      for (int h = 0; h < 2; h++)
        rxw[frm][pos/8][h] = ((pos % 8 == 0) ? 0 : rxw[frm][pos/8][h] * 2) + rb[h];
      if (pos == HALF)
        cdw[frm] = $unsigned($random(seed)) % 256;
      // Codec follows the block's direction and slave clock; while direction is high it toggles its output every link clock
      if (i_dir)
      begin
        cbit = 0;
        o_codec_data = ~o_codec_data;
      end
      else if (i_slave_clk && !sclk_d && cbit < 8 && frm >= 0)
      begin
        o_codec_data = 1'((cdw[frm] >> (7 - cbit)) & 1);
        cbit++;
      end
      sclk_d = i_slave_clk;
    end
  end
endmodule

// file: bench/pcm_highway_subscriber_timing_tb.sv
// Self-checking bench: per-cycle frame model against the block's outputs.
// Assumes the far side model drives sync, highways and the codec from the link clock.
`timescale 1ns/1ps
module pcm_highway_subscriber_timing_tb;
  import pcm_pkg::*;
  localparam int NS   = 8;
  localparam int BITS = NS * 8;
  logic       i_clk, i_nrst, i_link_clk, i_cfg_load, run;
  slot_cfg_t  cfg;
  logic       fsp, codec, pin, sclk, dir, strobe, sub_out, sub_oe;
  logic [1:0] rxd, txd, txoe, txdn;
  int         num_errors  = 0;
  int         check_count = 0;
  int         seed        = 82;
  int         chk_from    = 1000;
  int         q, fo, eoe;
  assign pin = sub_oe ? sub_out : codec;
  pcm_highway_subscriber_timing #(.NUM_SLOTS(NS)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cfg(cfg), .i_cfg_load(i_cfg_load),
    .i_link_clk(i_link_clk), .i_frame_sync_pulse(fsp), .i_rx_highway_data(rxd),
    .o_tx_highway_data(txd), .o_tx_highway_oe(txoe), .o_tx_highway_drive_n(txdn),
    .o_slave_clk(sclk), .o_dir(dir), .o_programmable_strobe(strobe),
    .i_subscriber_serial_port(pin), .o_subscriber_serial_port(sub_out),
    .o_subscriber_serial_port_oe(sub_oe));
  pcm_peer #(.NUM_SLOTS(NS)) u_peer (.i_link_clk(i_link_clk), .i_run(run),
    .i_slave_clk(sclk), .i_dir(dir),
    .o_frame_sync_pulse(fsp), .o_rx_highway_data(rxd), .o_codec_data(codec));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial
  begin
    i_link_clk = 1'b0;
    #3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  task automatic check(string name, int exp, logic [7:0] got);
    check_count++;
    if (got !== 8'(exp))
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, 8'(exp), got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // -------------------------------
  // Frame model, outputs lag the pin position by 3 link clocks
  // -------------------------------
  always @(negedge i_link_clk)
  begin
    q  = (u_peer.pos + BITS - 3) % BITS;
    fo = u_peer.frm - int'(u_peer.pos < 3);
    if (run && fo >= chk_from)
    begin
      eoe = (q / 8 == cfg.tx_slot) ? (1 << cfg.tx_hw) : 0;
      check("dir", int'(q < BITS / 2), dir);
      check("slave clock", int'(q % 2 == 0), sclk);
      check("strobe", int'(q / 8 == cfg.strobe_slot), strobe);
      check("sub oe", int'(q < 16), sub_oe);
      if (q < 16)
        check("sub data", (u_peer.rxw[fo-1][cfg.rx_slot][cfg.rx_hw] >> (7 - q / 2)) & 1, sub_out);
      check("tx oe", eoe, txoe);
      check("drive flag", 3 ^ eoe, txdn);
      if (eoe != 0)
        check("tx data", (u_peer.cdw[fo-1] >> (7 - q % 8)) & 1, txd[cfg.tx_hw]);
    end
  end
  initial
  begin
    i_nrst     = 1'b0;
    i_cfg_load = 1'b0;
    cfg        = RST_CFG;
    run        = 1'b0;
    repeat (16) @(posedge i_clk);
    check("reset drive flag", 3, txdn);
    #1 i_nrst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 run = 1'b1;
    for (int n = 0; n < 6; n++)
    begin
      @(posedge i_clk);
      #1;
      // Stop checking before the change so no frame mixes two settings
      chk_from = 1000;
      cfg.rx_slot     = 5'($unsigned($random(seed)) % NS);
      cfg.tx_slot     = 5'($unsigned($random(seed)) % NS);
      cfg.strobe_slot = 5'($unsigned($random(seed)) % NS);
      cfg.rx_hw       = ~n[0];
      cfg.tx_hw       = n[0];
      i_cfg_load      = 1'b1;
      @(posedge i_clk);
      #1 i_cfg_load = 1'b0;
      chk_from = u_peer.frm + 3;
      repeat (BITS * 6) @(posedge i_link_clk);
    end
    wrap_up();
  end
  initial
  begin
    #60000;
    num_errors++;
    wrap_up();
  end
endmodule
